// >>> rtl/mmc_measurement_control.sv
// Measurement mode control register: standby/active, one-shot, oversampling, soft reset.
// Assumes a same-clock register access port and a measurement engine with start/done.
`timescale 1ns/1ps
`default_nettype none

module mmc_measurement_control #(
  parameter int unsigned SECOND_CYCLES = mmc_pkg::MMC_SECOND_CYCLES,
  parameter int unsigned BOOT_CYCLES   = mmc_pkg::MMC_BOOT_CYCLES
) (
  input  wire logic       core_clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  input  wire logic [3:0] acq_interval_exponent_i,
  input  wire logic       meas_done_i,
  output logic            meas_start_o,
  output logic            active_o,
  output logic      [2:0] oversample_exponent_o,
  output logic      [7:0] oversample_ratio_o,
  output logic            boot_busy_o,
  output logic            block_reset_o,
  output logic            serial_reset_o
);

  mmc_pkg::mmc_top_state_t s_reg;
  mmc_pkg::mmc_top_state_t s_next;
  logic                    period_expire;
  logic                    wr_hit;
  logic                    w_rst;
  logic                    w_ost;
  logic                    w_act;

  ////////////////////////////////////////////////////////////////////////////
  // Periodic timer

  // Restart on the launching edge so starts stay 2^step seconds plus one cycle apart
  mmc_interval_timer #(
    .TICK_CYCLES (SECOND_CYCLES)
  ) u_timer (
    .core_clk_i  (core_clk_i),
    .reset_n_i   (reset_n_i),
    .run_i       (s_reg.state == mmc_pkg::MMC_ST_ACTIVE),
    .restart_i   (s_next.meas_start),
    .exponent_i  (acq_interval_exponent_i),
    .expire_o    (period_expire)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Control logic

  function automatic logic [7:0] os_ratio(input logic [2:0] e);
    os_ratio = 8'h01 << e;
  endfunction

  function automatic logic [7:0] read_value(input mmc_pkg::mmc_ctrl_t c);
    read_value = 8'h00;
    read_value[mmc_pkg::MMC_OS_MSB:mmc_pkg::MMC_OS_LSB] = c.oversample_exponent;
    read_value[mmc_pkg::MMC_ONE_SHOT_BIT]               = c.one_shot_trigger;
    read_value[mmc_pkg::MMC_ACTIVE_BIT]                 = c.active_not_standby;
  endfunction

  assign wr_hit = reg_wr_i && (reg_addr_i == mmc_pkg::MMC_REG_ADDR);
  assign w_rst  = reg_wdata_i[mmc_pkg::MMC_SOFT_RST_BIT];
  assign w_ost  = reg_wdata_i[mmc_pkg::MMC_ONE_SHOT_BIT];
  assign w_act  = reg_wdata_i[mmc_pkg::MMC_ACTIVE_BIT];

  always_comb begin
    s_next            = s_reg;
    s_next.meas_start = 1'b0;
    if (meas_done_i) begin
      s_next.meas_busy = 1'b0;
    end
    case (s_reg.state)
      mmc_pkg::MMC_ST_STANDBY: begin
        if (wr_hit && w_rst) begin
          s_next.soft_rst_pending = 1'b1;
          s_next.state            = mmc_pkg::MMC_ST_DRAIN;
        end else if (wr_hit) begin
          s_next.ctrl.oversample_exponent =
            reg_wdata_i[mmc_pkg::MMC_OS_MSB:mmc_pkg::MMC_OS_LSB];
          s_next.ctrl.active_not_standby  = w_act;
          s_next.ctrl.one_shot_trigger    = w_ost;
          s_next.launch_req               = w_ost;
          if (w_act) begin
            s_next.state = mmc_pkg::MMC_ST_ACTIVE;
          end else if (w_ost) begin
            s_next.state = mmc_pkg::MMC_ST_ONESHOT;
          end
        end
      end
      mmc_pkg::MMC_ST_ACTIVE: begin
        if (wr_hit && w_rst) begin
          s_next.soft_rst_pending        = 1'b1;
          s_next.ctrl.active_not_standby = 1'b0;
          s_next.launch_req              = 1'b0;
          s_next.state                   = mmc_pkg::MMC_ST_DRAIN;
        end else if (wr_hit) begin
          // only mode and one-shot bits change while active
          s_next.ctrl.active_not_standby = w_act;
          s_next.ctrl.one_shot_trigger   = w_ost;
          // trigger stays set in active mode
          if (w_ost && !s_reg.ctrl.one_shot_trigger) begin
            s_next.launch_req = 1'b1;
          end
          if (!w_act) begin
            s_next.launch_req = w_ost;
            s_next.state      = w_ost ? mmc_pkg::MMC_ST_ONESHOT : mmc_pkg::MMC_ST_STANDBY;
          end
        end else if (period_expire) begin
          s_next.launch_req = 1'b1;
        end
      end
      mmc_pkg::MMC_ST_ONESHOT: begin
        if (wr_hit && w_rst) begin
          s_next.soft_rst_pending = 1'b1;
          s_next.launch_req       = 1'b0;
          s_next.state            = mmc_pkg::MMC_ST_DRAIN;
        end else if (meas_done_i && s_reg.meas_busy && !s_reg.launch_req) begin
          s_next.ctrl.one_shot_trigger = 1'b0;
          s_next.state                 = mmc_pkg::MMC_ST_STANDBY;
        end
      end
      mmc_pkg::MMC_ST_DRAIN: begin
        s_next.launch_req = 1'b0;
        if (!s_reg.meas_busy) begin
          s_next.boot_cnt = '0;
          s_next.state    = mmc_pkg::MMC_ST_BOOT;
        end
      end
      mmc_pkg::MMC_ST_BOOT: begin
        s_next.ctrl       = mmc_pkg::mmc_ctrl_t'(mmc_pkg::MMC_REG_RESET[4:0]);
        s_next.launch_req = 1'b0;
        s_next.boot_cnt   = s_reg.boot_cnt + mmc_pkg::MMC_BOOT_W'(1);
        if (s_reg.boot_cnt == mmc_pkg::MMC_BOOT_W'(BOOT_CYCLES - 1)) begin
          // request bit cleared at boot end
          s_next.soft_rst_pending = 1'b0;
          s_next.state            = mmc_pkg::MMC_ST_STANDBY;
        end
      end
      default: begin
        s_next.state = mmc_pkg::MMC_ST_STANDBY;
      end
    endcase
    // Launch one measurement at a time
    if (s_next.launch_req && !s_next.meas_busy && s_next.state != mmc_pkg::MMC_ST_DRAIN
        && s_next.state != mmc_pkg::MMC_ST_BOOT) begin
      s_next.meas_start = 1'b1;
      s_next.meas_busy  = 1'b1;
      s_next.launch_req = 1'b0;
    end
    s_next.active = (s_next.state == mmc_pkg::MMC_ST_ACTIVE)
                 || (s_next.state == mmc_pkg::MMC_ST_ONESHOT);
    s_next.block_reset  = (s_next.state == mmc_pkg::MMC_ST_BOOT);
    s_next.serial_reset = (s_next.state == mmc_pkg::MMC_ST_BOOT);
    s_next.os_ratio     = os_ratio(s_next.ctrl.oversample_exponent);
    s_next.rdata = (reg_rd_i && reg_addr_i == mmc_pkg::MMC_REG_ADDR)
                 ? read_value(s_reg.ctrl) : 8'h00;
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_reg          <= '0;
      s_reg.state    <= mmc_pkg::MMC_ST_STANDBY;
      s_reg.os_ratio <= 8'h01;
    end else begin
      s_reg <= s_next;
    end
  end

  assign reg_rdata_o           = s_reg.rdata;
  assign meas_start_o          = s_reg.meas_start;
  assign active_o              = s_reg.active;
  assign oversample_exponent_o = s_reg.ctrl.oversample_exponent;
  assign oversample_ratio_o    = s_reg.os_ratio;
  assign boot_busy_o           = s_reg.soft_rst_pending;
  assign block_reset_o         = s_reg.block_reset;
  assign serial_reset_o        = s_reg.serial_reset;

endmodule // mmc_measurement_control
`default_nettype wire

// >>> rtl/mmc_pkg.sv
// Constants, field layout and state types for the measurement mode control block.
// Assumes a single 20 MHz core clock.
package mmc_pkg;

  // Register map and field layout
  localparam logic [7:0] MMC_REG_ADDR      = 8'h26;
  localparam logic [7:0] MMC_REG_RESET     = 8'h00;
  localparam int         MMC_ACTIVE_BIT    = 0;
  localparam int         MMC_ONE_SHOT_BIT  = 1;
  localparam int         MMC_SOFT_RST_BIT  = 2;
  localparam int         MMC_OS_LSB        = 3;
  localparam int         MMC_OS_MSB        = 5;

  // Timing
  localparam int unsigned MMC_CLK_PERIOD_NS = 50;
  localparam int unsigned MMC_ONE_SECOND_NS = 1000000000;
  localparam int unsigned MMC_SECOND_CYCLES = MMC_ONE_SECOND_NS / MMC_CLK_PERIOD_NS;
  localparam int unsigned MMC_BOOT_CYCLES   = 16;
  localparam int          MMC_TICK_W        = 25;
  localparam int          MMC_SEC_W         = 16;
  localparam int          MMC_BOOT_W        = 8;

  typedef enum logic [4:0] {
    MMC_ST_STANDBY = 5'b00001,
    MMC_ST_ONESHOT = 5'b00010,
    MMC_ST_ACTIVE  = 5'b00100,
    MMC_ST_DRAIN   = 5'b01000,
    MMC_ST_BOOT    = 5'b10000
  } mmc_state_t;

  typedef struct packed {
    logic [2:0] oversample_exponent;
    logic       one_shot_trigger;
    logic       active_not_standby;
  } mmc_ctrl_t;

  typedef struct packed {
    mmc_state_t            state;
    mmc_ctrl_t             ctrl;
    logic                  soft_rst_pending;
    logic                  launch_req;
    logic                  meas_busy;
    logic [MMC_BOOT_W-1:0] boot_cnt;
    logic                  meas_start;
    logic                  active;
    logic                  block_reset;
    logic                  serial_reset;
    logic [7:0]            rdata;
    logic [7:0]            os_ratio;
  } mmc_top_state_t;

  typedef struct packed {
    logic [MMC_TICK_W-1:0] cyc;
    logic [MMC_SEC_W-1:0]  sec;
    logic                  expire;
  } mmc_timer_state_t;

endpackage

// >>> rtl/mmc_interval_timer.sv
// Periodic acquisition timer: one pulse every 2^exponent seconds while running.
// Assumes exponent is held steady while running.
`timescale 1ns/1ps
`default_nettype none
module mmc_interval_timer #(
  parameter int unsigned TICK_CYCLES = mmc_pkg::MMC_SECOND_CYCLES
) (
  input  wire logic       core_clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       run_i,
  input  wire logic       restart_i,
  input  wire logic [3:0] exponent_i,
  output logic            expire_o
);

  mmc_pkg::mmc_timer_state_t s_reg;
  mmc_pkg::mmc_timer_state_t s_next;

  // 2^exponent seconds, minus one
  function automatic logic [mmc_pkg::MMC_SEC_W-1:0] last_second(input logic [3:0] e);
    last_second = (mmc_pkg::MMC_SEC_W'(1) << e) - mmc_pkg::MMC_SEC_W'(1);
  endfunction

  always_comb begin
    s_next        = s_reg;
    s_next.expire = 1'b0;
    if (!run_i || restart_i) begin
      s_next.cyc = '0;
      s_next.sec = '0;
    end else if (s_reg.cyc == mmc_pkg::MMC_TICK_W'(TICK_CYCLES - 1)) begin
      s_next.cyc = '0;
      if (s_reg.sec == last_second(exponent_i)) begin
        s_next.sec    = '0;
        s_next.expire = 1'b1;
      end else begin
        s_next.sec = s_reg.sec + mmc_pkg::MMC_SEC_W'(1);
      end
    end else begin
      s_next.cyc = s_reg.cyc + mmc_pkg::MMC_TICK_W'(1);
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign expire_o = s_reg.expire;

endmodule // mmc_interval_timer
`default_nettype wire

// >>> testbench/mmc_assertions.sv
// Checker for the measurement mode control block.
// Assumes it is bound to the ports of mmc_measurement_control.
`timescale 1ns/1ps
`default_nettype none
module mmc_assertions #(
  parameter int unsigned BOOT_CYCLES = 16
) (
  input wire logic       core_clk_i,
  input wire logic       reset_n_i,
  input wire logic       reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       meas_start_o,
  input wire logic       active_o,
  input wire logic [2:0] oversample_exponent_o,
  input wire logic [7:0] oversample_ratio_o,
  input wire logic       boot_busy_o,
  input wire logic       block_reset_o,
  input wire logic       serial_reset_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  logic       wr_hit;
  logic [7:0] hi_cnt;
  assign wr_hit = reg_wr_i && reg_addr_i == 8'h26;
  // Length of the current reset pulse
  always_ff @(posedge core_clk_i or negedge reset_n_i)
    if (!reset_n_i) hi_cnt <= 8'h00;
    else hi_cnt <= block_reset_o ? hi_cnt + 8'h01 : 8'h00;
  ////////////////////////////////////////
  a_ratio_power: assert property (
    oversample_ratio_o == (8'h01 << oversample_exponent_o)) else $error("ratio wrong");
  a_rst_bit_zero: assert property (
    reg_rdata_o[2] == 1'b0 && reg_rdata_o[7:6] == 2'b00) else $error("zero bits set");
  a_boot_standby: assert property (
    boot_busy_o |-> !active_o && !meas_start_o) else $error("active during boot");
  a_serial_with: assert property (
    serial_reset_o == block_reset_o) else $error("serial reset differs");
  a_boot_length: assert property (
    $fell(block_reset_o) |-> hi_cnt == BOOT_CYCLES) else $error("reset pulse length");
  a_reload_defaults: assert property (
    $fell(block_reset_o) |-> oversample_exponent_o == 3'h0) else $error("no reload");
  a_reset_wins: assert property (
    wr_hit && reg_wdata_i[2] && !boot_busy_o |=> boot_busy_o && !meas_start_o)
    else $error("reset not taken");
  a_mode_enter: assert property (
    wr_hit && reg_wdata_i[2:0] inside {3'b001, 3'b010} && !active_o && !boot_busy_o
    |=> active_o) else $error("mode not entered");
  c_boot: cover property ($rose(block_reset_o));
  c_start: cover property (meas_start_o && active_o);
  c_stop: cover property ($fell(active_o));
endmodule // mmc_assertions
bind mmc_measurement_control mmc_assertions #(.BOOT_CYCLES(BOOT_CYCLES)) u_chk (
  .core_clk_i, .reset_n_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
  .meas_start_o, .active_o, .oversample_exponent_o, .oversample_ratio_o,
  .boot_busy_o, .block_reset_o, .serial_reset_o);
`default_nettype wire

// >>> testbench/mmc_meas_engine.sv
// Measurement engine model: done pulse a set latency after start.
// Assumes the same core clock and reset as the block.
`timescale 1ns/1ps
`default_nettype none
module mmc_meas_engine (
  input  wire logic       core_clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       start_i,
  input  wire logic [7:0] latency_i,
  output logic            done_o
);
  logic [7:0] cnt_reg;
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_reg <= 8'h00;
      done_o  <= 1'b0;
    end else begin
      done_o <= cnt_reg == 8'h01;
      if (start_i)
        cnt_reg <= latency_i;
      else if (cnt_reg != 8'h00)
        cnt_reg <= cnt_reg - 8'h01;
    end
  end
endmodule // mmc_meas_engine
`default_nettype wire

// >>> testbench/mmc_measurement_control_tb.sv
// Self-checking bench for the measurement mode control block.
// Assumes the engine model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module mmc_measurement_control_tb;
  logic       core_clk_i, reset_n_i, reg_wr_i, reg_rd_i, done;
  logic [7:0] reg_addr_i, reg_wdata_i, lat, reg_rdata_o, ratio;
  logic [3:0] acq_exp;
  logic [2:0] os_exp;
  logic       start, active, busy, blk_rst, ser_rst;
  int         fails, samples_checked, n;
  mmc_measurement_control #(.SECOND_CYCLES(10), .BOOT_CYCLES(4)) DUT (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .acq_interval_exponent_i(acq_exp), .meas_done_i(done),
    .meas_start_o(start), .active_o(active), .oversample_exponent_o(os_exp),
    .oversample_ratio_o(ratio), .boot_busy_o(busy), .block_reset_o(blk_rst),
    .serial_reset_o(ser_rst));
  mmc_meas_engine u_eng (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .start_i(start), .latency_i(lat), .done_o(done));
  ////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] exp);
    @(posedge core_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= 8'h26;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(reg_rdata_o, exp);
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return start;
      1: return active;
      2: return blk_rst;
      default: return busy;
    endcase
  endfunction
  // Bounded wait for a level, then compare
  task automatic wt(input int s, input logic v, input int lim);
    for (n = 0; n < lim && sig(s) !== v; n++) begin
      @(posedge core_clk_i);
      #1;
    end
    chk({7'h00, sig(s)}, {7'h00, v});
  endtask
  task automatic conclude();
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end
  initial begin
    #1000000;
    $display("[FAIL] %0t watchdog expired", $time);
    fails++;
    conclude();
  end
  initial begin
    reset_n_i = 1'b0;
    {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, acq_exp} = '0;
    lat = 8'h03;
    repeat (8) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    rd(8'h00);
    chk(ratio, 8'h01);
    wr(8'h27, 8'h01);
    chk({7'h00, active}, 8'h00);
    $display("test reset done");
    for (int e = 0; e < 8; e++) begin
      wr(8'h26, {2'b11, 3'(e), 3'b000});
      chk(ratio, 8'h01 << e);
      chk(os_exp, {5'h00, 3'(e)});
      rd({2'b00, 3'(e), 3'b000});
    end
    $display("test oversample done");
    wr(8'h26, 8'h3a);
    wt(0, 1'b1, 2);
    wt(1, 1'b0, 20);
    rd(8'h38);
    $display("test standby shot done");
    wr(8'h26, 8'h00);
    @(posedge core_clk_i);
    acq_exp <= 4'h1;
    wr(8'h26, 8'h01);
    wt(0, 1'b1, 30);
    @(posedge core_clk_i);
    #1;
    wt(0, 1'b1, 30);
    chk({7'h00, n == 19 || n == 20}, 8'h01);
    wr(8'h26, 8'h19);
    rd(8'h01);
    wr(8'h26, 8'h03);
    wt(0, 1'b1, 6);
    rd(8'h03);
    wr(8'h26, 8'h01);
    wr(8'h26, 8'h03);
    wt(0, 1'b1, 6);
    wr(8'h26, 8'h00);
    chk({7'h00, active}, 8'h00);
    $display("test active done");
    @(posedge core_clk_i);
    lat <= 8'h28;
    wr(8'h26, 8'h01);
    wr(8'h26, 8'h03);
    wt(0, 1'b1, 6);
    wr(8'h26, 8'h04);
    chk({6'h00, busy, active}, 8'h02);
    wt(2, 1'b1, 60);
    chk({6'h00, blk_rst, ser_rst}, 8'h03);
    wt(2, 1'b0, 20);
    chk(8'(n), 8'h04);
    wt(3, 1'b0, 4);
    rd(8'h00);
    $display("test active reset done");
    @(posedge core_clk_i);
    lat <= 8'h03;
    wr(8'h26, 8'h06);
    chk({6'h00, busy, start}, 8'h02);
    wt(3, 1'b0, 30);
    rd(8'h00);
    $display("test reset wins done");
    conclude();
  end
endmodule // mmc_measurement_control_tb
`default_nettype wire
